// ---- hdl/pcic_pkg.sv ----
// Purpose: Shared constants and types of the initiator control block
// Assumes: 32-bit AHB-Lite register bus, word access only
// Notes: Offsets are byte addresses within the register space
package pcic_pkg;
   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [15:0] OFF_TIMEOUT = 16'hd040;
   localparam logic [15:0] OFF_CONFIG = 16'hd060;
   localparam logic [15:0] OFF_STATUS = 16'hd064;
   localparam logic [15:0] OFF_MASK = 16'hd068;
   localparam logic [15:0] OFF_SHADOW = 16'hd088;

   // ------------------------------------------------------------
   // Configuration fields
   // ------------------------------------------------------------
   localparam int CFG_SWAP_LO = 8;        // Swap bits 11:8, window 0 at 11
   localparam int CFG_EN_LO = 4;          // Enable bits 7:4, window 0 at 7
   localparam int CFG_M2_EN = 5;
   localparam int CFG_RESP = 3;
   localparam int CFG_SWAP_SPC = 1;
   localparam int CFG_SERR = 0;
   localparam logic [11:0] CFG_WMASK = 12'hffa; // Bits 2 and 0 not stored
   localparam logic [11:0] CFG_RESET = 12'h008; // Before straps apply

   // ------------------------------------------------------------
   // Status, mask and shadow fields
   // ------------------------------------------------------------
   localparam int ST_OUT_EMPTY = 8;
   localparam int ST_IN_EMPTY = 7;
   localparam int ST_FATAL = 6;
   localparam int ST_PARITY = 5;
   localparam int ST_READY_TO = 1;
   localparam int ST_RETRY_TO = 0;
   localparam int SH_PS_LO = 24;
   localparam int SH_FLAGS_LO = 11;       // Bits 15:11
   localparam int SH_DT_LO = 9;
   localparam int SH_DIRECT_PARITY_FLAG = 8;
   localparam logic [1:0] DT_VALUE = 2'h1;

   // ------------------------------------------------------------
   // Timeout limits and counts
   // ------------------------------------------------------------
   localparam int TO_RETRY_LO = 8;
   localparam logic [7:0] LIMIT_RESET = 8'h80;
   localparam logic [1:0] STRAP_LOAD_CNT = 2'h2; // Sync depth
   localparam logic [1:0] INIT_DONE_CNT = 2'h3;

   // ------------------------------------------------------------
   // System-error pulse sequencer
   // ------------------------------------------------------------
   typedef enum logic [1:0] {SERR_IDLE, SERR_PEND, SERR_ACTIVE} pcic_serr_t;
endpackage

// ---- hdl/pcic_initiator_ctrl.sv ----
// Purpose: Control, status and mask registers of a PCI initiator
// Assumes: Event inputs are one-cycle pulses on clk; straps and the
//          PCI clock arrive asynchronously
// Notes: Zero-wait AHB-Lite slave, response always OKAY
// Notes on behaviour
// RQ1: Per-window swap bit, reset from endian strap
// RQ2: Cleared swap passes word bytes unchanged
// RQ3: Memory windows 0/1 gated by enables
// RQ4: Window 2 enable resets from boot strap
// RQ5: I/O window gated by its enable
// RQ6: Failed read gives bus error or invalid data
// RQ7: Special-cycle swap bit, reset from endian strap
// RQ8: Writing one pulses SERR one PCI clock
// RQ9: FIFO empty flags read-only, reset one
// RQ10: Aborts and timeouts set fatal flag
// RQ11: Parity error sets parity flag
// RQ12: Timeouts set their own flags
// RQ13: Error flags sticky, write one clears
// RQ14: Mask bits enable each error interrupt
// RQ15: Satellite mode mirrors power state bits
// RQ16: Shadow mirrors six PCI status flags
// RQ17: Device-select timing reads fixed 01
// RQ18: Satellite mode blocks status/power writes
// RQ19: Retries above limit end in error
// RQ20: Ready wait above limit gives timeout
// RQ21: Interrupt is OR of enabled flags
// RQ22: Zero write keeps flag; set beats clear
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
module pcic_initiator_ctrl (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Asynchronous pins and straps
   input wire logic pciClk,
   input wire logic bigEndianStrap,
   input wire logic pciBootStrap,
   input wire logic satelliteMode,
   // Open-drain system error pin
   output logic serrOut,
   output logic serrOe,
   // Initiator engine events and state
   input wire logic txnStart,
   input wire logic evMasterAbort,
   input wire logic evTargetAbort,
   input wire logic evParity,
   input wire logic retryTerm,
   input wire logic readyWait,
   input wire logic readEnd,
   input wire logic outFifoEmpty,
   input wire logic inFifoEmpty,
   output logic retryTimeout,
   output logic readyTimeout,
   output logic sysBusError,
   output logic readDataInvalid,
   // Window access check, 0..2 memory, 3 I/O
   input wire logic reqValid,
   input wire logic [1:0] reqWindow,
   output logic reqPermit,
   // Byte swap path
   input wire logic xferValid,
   input wire logic xferSpecial,
   input wire logic [1:0] xferWindow,
   input wire logic [31:0] xferData,
   output logic [31:0] swapData,
   // Configuration space shadow sources
   input wire logic [5:0] pciStatusFlags,
   input wire logic [1:0] powerState,
   input wire logic cfgWrReq,
   output logic cfgWrAllow,
   // Interrupt
   output logic initIrq
);
   // ------------------------------------------------------------
   // Synchronisers and PCI clock edge
   // ------------------------------------------------------------
   logic [3:0] syncA_q; // First stage, read only by second
   logic [3:0] syncB_q; // {pciClk, bigEndian, pciBoot, satellite}
   logic pciPrev_q;
   logic pciRise;
   logic bigEnd;
   logic pciBoot;
   logic sat;

   // Two flops per asynchronous input
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         syncA_q <= 4'h0;
         syncB_q <= 4'h0;
         pciPrev_q <= 1'b0;
      end else begin
         syncA_q <= {pciClk, bigEndianStrap, pciBootStrap, satelliteMode};
         syncB_q <= syncA_q;
         pciPrev_q <= syncB_q[3];
      end
   end

   assign pciRise = syncB_q[3] & ~pciPrev_q;
   assign bigEnd = syncB_q[2];
   assign pciBoot = syncB_q[1];
   assign sat = syncB_q[0];

   // ------------------------------------------------------------
   // Strap capture after reset release
   // ------------------------------------------------------------
   logic [1:0] initCnt_q;
   logic strapLoad;

   // Wait for the synchronisers to fill before taking straps
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         initCnt_q <= 2'h0;
      end else if (initCnt_q != pcic_pkg::INIT_DONE_CNT) begin
         initCnt_q <= initCnt_q + 2'h1;
      end
   end

   assign strapLoad = (initCnt_q == pcic_pkg::STRAP_LOAD_CNT);

   // ------------------------------------------------------------
   // AHB-Lite address phase capture
   // ------------------------------------------------------------
   logic wrPend_q;
   logic [15:0] wrAddr_q;
   logic rdTake;
   logic wrCfg;
   logic wrSt;
   logic wrMask;
   logic wrTo;

   assign rdTake = hsel & htrans[1] & hready & ~hwrite;

   // Write data arrives one cycle after its address
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wrPend_q <= 1'b0;
         wrAddr_q <= 16'h0000;
      end else begin
         wrPend_q <= hsel & htrans[1] & hready & hwrite;
         wrAddr_q <= haddr[15:0];
      end
   end

   // Unmapped offsets fall through every decode and are dropped
   assign wrCfg = wrPend_q & (wrAddr_q == pcic_pkg::OFF_CONFIG);
   assign wrSt = wrPend_q & (wrAddr_q == pcic_pkg::OFF_STATUS);
   assign wrMask = wrPend_q & (wrAddr_q == pcic_pkg::OFF_MASK);
   assign wrTo = wrPend_q & (wrAddr_q == pcic_pkg::OFF_TIMEOUT);
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // ------------------------------------------------------------
   // Configuration register
   // ------------------------------------------------------------
   logic [11:0] cfg_q; // Bits 2 and 0 held at zero

   // Straps seed swap bits and the window 2 enable once
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cfg_q <= pcic_pkg::CFG_RESET;
      end else if (strapLoad) begin
         cfg_q[11:8] <= {4{bigEnd}}; // RQ1
         cfg_q[pcic_pkg::CFG_SWAP_SPC] <= bigEnd; // RQ7
         cfg_q[pcic_pkg::CFG_M2_EN] <= pciBoot; // RQ4
      end else if (wrCfg) begin
         cfg_q <= hwdata[11:0] & pcic_pkg::CFG_WMASK;
      end
   end

   // ------------------------------------------------------------
   // Window permission and byte swap
   // ------------------------------------------------------------
   logic [3:0] winEn; // Index 0..3 = window 0,1,2,I/O
   logic [3:0] winSwap;
   logic doSwap;

   assign winEn = {cfg_q[4], cfg_q[5], cfg_q[6], cfg_q[7]};
   assign winSwap = {cfg_q[8], cfg_q[9], cfg_q[10], cfg_q[11]};
   assign reqPermit = reqValid & winEn[reqWindow]; // RQ3 RQ4 RQ5

   assign doSwap = xferSpecial ? cfg_q[pcic_pkg::CFG_SWAP_SPC] : winSwap[xferWindow];

   // Registered swap; a clear bit passes the word as is
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         swapData <= 32'h00000000;
      end else if (xferValid) begin
         if (doSwap) begin
            swapData <= {xferData[7:0], xferData[15:8], xferData[23:16], xferData[31:24]}; // RQ1 RQ7
         end else begin
            swapData <= xferData; // RQ2
         end
      end
   end

   // ------------------------------------------------------------
   // System error pulse, one PCI clock long
   // ------------------------------------------------------------
   pcic_pkg::pcic_serr_t serrSt_q;
   logic serrReq;

   assign serrReq = wrCfg & hwdata[pcic_pkg::CFG_SERR];

   // Aligned to PCI rising edges so the pulse spans one whole period
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         serrSt_q <= pcic_pkg::SERR_IDLE;
      end else begin
         unique case (serrSt_q)
            pcic_pkg::SERR_IDLE: begin
               if (serrReq) begin
                  serrSt_q <= pcic_pkg::SERR_PEND;
               end
            end
            pcic_pkg::SERR_PEND: begin
               if (pciRise) begin
                  serrSt_q <= pcic_pkg::SERR_ACTIVE; // RQ8
               end
            end
            pcic_pkg::SERR_ACTIVE: begin
               // A new request in the cycle of the closing PCI rise queues another
               if (pciRise) begin
                  serrSt_q <= serrReq ? pcic_pkg::SERR_PEND : pcic_pkg::SERR_IDLE; // RQ8
               end
            end
            default: begin
               serrSt_q <= pcic_pkg::SERR_IDLE;
            end
         endcase
      end
   end

   assign serrOut = 1'b0;
   assign serrOe = (serrSt_q == pcic_pkg::SERR_ACTIVE);

   // ------------------------------------------------------------
   // Timeout limits and counters
   // ------------------------------------------------------------
   logic [7:0] retryLim_q;
   logic [7:0] readyLim_q;
   logic [8:0] retryCnt_q;
   logic [8:0] readyCnt_q;

   // Software limits, zero disables
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         retryLim_q <= pcic_pkg::LIMIT_RESET;
         readyLim_q <= pcic_pkg::LIMIT_RESET;
      end else if (wrTo) begin
         retryLim_q <= hwdata[15:8];
         readyLim_q <= hwdata[7:0];
      end
   end

   // Fires on the retry that takes the count past the limit
   assign retryTimeout = retryTerm & (retryLim_q != 8'h00) & (retryCnt_q == {1'b0, retryLim_q}); // RQ19
   // Ready wait counted in PCI clocks
   assign readyTimeout = readyWait & pciRise & (readyLim_q != 8'h00) &
                         (readyCnt_q == {1'b0, readyLim_q}); // RQ20

   // Retries per transaction, saturating past the limit
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         retryCnt_q <= 9'h000;
      end else if (txnStart) begin
         retryCnt_q <= 9'h000;
      end else if (retryTerm && retryCnt_q <= {1'b0, retryLim_q}) begin
         retryCnt_q <= retryCnt_q + 9'h001;
      end
   end

   // Ready wait length, restarts whenever the wait ends
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         readyCnt_q <= 9'h000;
      end else if (!readyWait) begin
         readyCnt_q <= 9'h000;
      end else if (pciRise && readyCnt_q <= {1'b0, readyLim_q}) begin
         readyCnt_q <= readyCnt_q + 9'h001;
      end
   end

   // ------------------------------------------------------------
   // Sticky error flags and FIFO diagnostics
   // ------------------------------------------------------------
   logic [3:0] flags_q; // {fatal, parity, ready, retry}
   logic [3:0] flagSet;
   logic [3:0] flagClr;
   logic [1:0] fifoEmpty_q;

   assign flagSet = {evMasterAbort | evTargetAbort | readyTimeout | retryTimeout, // RQ10
                     evParity, readyTimeout, retryTimeout}; // RQ11 RQ12
   assign flagClr = wrSt ? {hwdata[6], hwdata[5], hwdata[1], hwdata[0]} : 4'h0;

   // Write one clears, zero keeps, set beats clear
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flags_q <= 4'h0;
      end else begin
         flags_q <= (flags_q & ~flagClr) | flagSet; // RQ13 RQ22
      end
   end

   // Registered FIFO empties, read-only
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fifoEmpty_q <= 2'h3;
      end else begin
         fifoEmpty_q <= {outFifoEmpty, inFifoEmpty}; // RQ9
      end
   end

   // ------------------------------------------------------------
   // Read failure response
   // ------------------------------------------------------------
   logic txnFail_q;
   logic failNow;

   assign failNow = txnFail_q | (|flagSet);

   // Any fatal or parity event marks the running transaction
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         txnFail_q <= 1'b0;
      end else if (txnStart) begin
         txnFail_q <= 1'b0;
      end else if (|flagSet) begin
         txnFail_q <= 1'b1;
      end
   end

   // Bus error or normal end with bad data, one cycle after readEnd
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sysBusError <= 1'b0;
         readDataInvalid <= 1'b0;
      end else begin
         sysBusError <= readEnd & failNow & cfg_q[pcic_pkg::CFG_RESP]; // RQ6
         readDataInvalid <= readEnd & failNow & ~cfg_q[pcic_pkg::CFG_RESP]; // RQ6
      end
   end

   // ------------------------------------------------------------
   // Interrupt mask and output
   // ------------------------------------------------------------
   logic [3:0] mask_q; // Same order as flags_q

   // Mask bits 6, 5, 1, 0
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mask_q <= 4'h0;
      end else if (wrMask) begin
         mask_q <= {hwdata[6], hwdata[5], hwdata[1], hwdata[0]}; // RQ14
      end
   end

   // Registered, so it follows the flags by one cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         initIrq <= 1'b0;
      end else begin
         initIrq <= |(flags_q & mask_q); // RQ21
      end
   end

   // ------------------------------------------------------------
   // Satellite shadow
   // ------------------------------------------------------------
   logic [5:0] shFlags_q;
   logic [1:0] shPs_q;

   // Status flags track the config space every cycle; power state only in satellite mode
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         shFlags_q <= 6'h00;
         shPs_q <= 2'h0;
      end else begin
         shFlags_q <= pciStatusFlags; // RQ16
         shPs_q <= sat ? powerState : 2'h0; // RQ15
      end
   end

   // Reads stay open, writes are held back in satellite mode
   assign cfgWrAllow = cfgWrReq & ~sat; // RQ18

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   logic [31:0] rdMux;

   // Reserved bits read as zero, unmapped reads give zero
   always_comb begin
      rdMux = 32'h00000000;
      unique case (haddr[15:0])
         pcic_pkg::OFF_CONFIG: rdMux[11:0] = cfg_q; // RQ8
         pcic_pkg::OFF_STATUS: begin
            rdMux[8:7] = fifoEmpty_q;
            rdMux[6:5] = flags_q[3:2];
            rdMux[1:0] = flags_q[1:0];
         end
         pcic_pkg::OFF_MASK: begin
            rdMux[6:5] = mask_q[3:2];
            rdMux[1:0] = mask_q[1:0];
         end
         pcic_pkg::OFF_SHADOW: begin
            rdMux[25:24] = shPs_q;
            rdMux[15:11] = shFlags_q[5:1];
            rdMux[10:9] = pcic_pkg::DT_VALUE; // RQ17
            rdMux[8] = shFlags_q[0];
         end
         pcic_pkg::OFF_TIMEOUT: rdMux[15:0] = {retryLim_q, readyLim_q};
         default: rdMux = 32'h00000000;
      endcase
   end

   // Loaded at the address phase, stands in the data phase
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hrdata <= 32'h00000000;
      end else if (rdTake) begin
         hrdata <= rdMux;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   property p_set_wins;
      evParity |=> flags_q[2];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("parity flag lost"); // RQ22

   property p_fatal_set;
      (evMasterAbort || evTargetAbort) |=> flags_q[3] && txnFail_q;
   endproperty
   a_fatal_set: assert property (p_fatal_set) else $error("fatal flag not set"); // RQ10

   property p_clear;
      wrSt && hwdata[0] && !retryTimeout |=> !flags_q[0];
   endproperty
   a_clear: assert property (p_clear) else $error("retry flag not cleared"); // RQ13

   property p_serr_start;
      $rose(serrOe) |-> $past(pciRise) && !pciRise;
   endproperty
   a_serr_start: assert property (p_serr_start) else $error("serr start off edge"); // RQ8

   property p_serr_end;
      serrOe && pciRise |=> !serrOe;
   endproperty
   a_serr_end: assert property (p_serr_end) else $error("serr too long"); // RQ8

   property p_cfg_bit0;
      rdTake && haddr[15:0] == pcic_pkg::OFF_CONFIG |=> !hrdata[0];
   endproperty
   a_cfg_bit0: assert property (p_cfg_bit0) else $error("serr bit reads one"); // RQ8

   property p_dt;
      rdTake && haddr[15:0] == pcic_pkg::OFF_SHADOW |=> hrdata[10:9] == 2'h1;
   endproperty
   a_dt: assert property (p_dt) else $error("devsel timing wrong"); // RQ17

   property p_permit;
      reqValid && reqWindow == 2'h0 && !cfg_q[7] |-> !reqPermit;
   endproperty
   a_permit: assert property (p_permit) else $error("window 0 access leaked"); // RQ3

   property p_resp;
      readEnd && txnFail_q |=> sysBusError == $past(cfg_q[3]) && readDataInvalid != sysBusError;
   endproperty
   a_resp: assert property (p_resp) else $error("read error response wrong"); // RQ6

   property p_irq;
      (flags_q & mask_q) == 4'h0 |=> !initIrq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq without enabled flag"); // RQ21

   property p_retry_off;
      retryLim_q == 8'h00 |-> !retryTimeout;
   endproperty
   a_retry_off: assert property (p_retry_off) else $error("retry limit zero fired"); // RQ19

   property p_ready_off;
      readyLim_q == 8'h00 |-> !readyTimeout;
   endproperty
   a_ready_off: assert property (p_ready_off) else $error("ready limit zero fired"); // RQ20

   property p_sat;
      sat |-> !cfgWrAllow;
   endproperty
   a_sat: assert property (p_sat) else $error("satellite write allowed"); // RQ18
endmodule

// ---- sim/pcic_pci_agent.sv ----
// Purpose: Far-side PCI agent: bus clock and pulled-up error line
// Assumes: Bus clock runs free with an 80 ns period
// Notes: Counts bus clock edges that see the error line low
`timescale 1ns/1ps
module pcic_pci_agent (
   // Bus clock toward the block
   output logic pciClk,
   // Error pin halves and resolved wire
   input wire logic serrOut,
   input wire logic serrOe,
   output logic serrWire,
   output int lowClocks
);
   // ----------------------------------------
   // Clock and wire
   // ----------------------------------------
   // Free-running bus clock, as on a real segment
   initial begin
      pciClk = 1'b0;
      forever #40 pciClk = ~pciClk;
   end
   // Pull-up holds the line high unless the block drives it
   assign serrWire = serrOe ? serrOut : 1'b1;
   // Count low samples so a stretched pulse shows up
   // Two-state count starts at zero, so one process owns it
   always @(posedge pciClk) begin
      if (serrWire === 1'b0) begin
         lowClocks <= lowClocks + 1;
      end
   end
endmodule

// ---- sim/pcic_initiator_ctrl_bench.sv ----
// Purpose: Self-checking bench of the initiator control block
// Assumes: Zero-wait slave; straps give big endian, normal boot
// Notes: One task per scenario; a cycle ceiling cuts hangs
`timescale 1ns/1ps
module pcic_initiator_ctrl_bench;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic clk, rstn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, xferData, swapData, r;
   logic [1:0] htrans, reqWindow, xferWindow, powerState;
   logic pciClk, bigEndianStrap, pciBootStrap, satelliteMode, serrOut, serrOe, serrWire;
   logic txnStart, evMasterAbort, evTargetAbort, evParity, retryTerm, readyWait, readEnd;
   logic outFifoEmpty, inFifoEmpty, retryTimeout, readyTimeout, sysBusError, readDataInvalid;
   logic reqValid, reqPermit, xferValid, xferSpecial, cfgWrReq, cfgWrAllow, initIrq;
   logic [5:0] pciStatusFlags;
   int fail_count = 0, check_count = 0, cyc = 0, lowClocks;
   // Block under test; bus hready loops back from the one slave
   pcic_initiator_ctrl DUT (.hready(hreadyout), .hsize(3'h2), .*);
   // Far-side agent
   pcic_pci_agent PTR (.*);
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // One single AHB transfer; read data taken at the data-phase edge
   task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {16'h0000, a};
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(r, e);
   endtask
   task automatic give_verdict;
      $display("Checks %0d, mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      rd(pcic_pkg::OFF_CONFIG, 32'hf0a);
      rd(pcic_pkg::OFF_STATUS, 32'h180);
      rd(pcic_pkg::OFF_MASK, 32'h0);
      rd(pcic_pkg::OFF_SHADOW, 32'h200);
      rd(pcic_pkg::OFF_TIMEOUT, 32'h8080);
      rd(16'hd070, 32'h0);
   endtask
   // Window 0 swaps; window 1 disabled; byte reply otherwise unchanged
   task automatic t_swap;
      // Special cycles swap while the big-endian default stands
      xferSpecial <= 1'b1;
      xferValid <= 1'b1;
      @(posedge clk);
      xferSpecial <= 1'b0;
      xferValid <= 1'b0;
      @(posedge clk);
      chk(swapData, 32'h44332211);
      bus(1'b1, pcic_pkg::OFF_CONFIG, 32'h8b0);
      for (int w = 0; w < 4; w++) begin
         reqValid <= 1'b1;
         reqWindow <= w[1:0];
         xferValid <= 1'b1;
         xferWindow <= w[1:0];
         @(posedge clk);
         xferValid <= 1'b0;
         chk(reqPermit, w != 1);
         @(posedge clk);
         chk(swapData, w == 0 ? 32'h44332211 : 32'h11223344);
      end
   endtask
   task automatic t_flags;
      bus(1'b1, pcic_pkg::OFF_MASK, 32'h20);
      txnStart <= 1'b1;
      @(posedge clk);
      txnStart <= 1'b0;
      evParity <= 1'b1;
      readEnd <= 1'b1;
      @(posedge clk);
      evParity <= 1'b0;
      readEnd <= 1'b0;
      @(posedge clk);
      chk({sysBusError, readDataInvalid}, 2'b01);
      @(posedge clk);
      chk(initIrq, 1'b1);
      bus(1'b1, pcic_pkg::OFF_STATUS, 32'h0);
      rd(pcic_pkg::OFF_STATUS, 32'h1a0);
      // A clear that meets a fresh parity event in its data phase loses
      fork
         bus(1'b1, pcic_pkg::OFF_STATUS, 32'h20);
         begin
            @(posedge clk);
            evParity <= 1'b1;
            @(posedge clk);
            evParity <= 1'b0;
         end
      join
      rd(pcic_pkg::OFF_STATUS, 32'h1a0);
      bus(1'b1, pcic_pkg::OFF_STATUS, 32'h20);
      evMasterAbort <= 1'b1;
      @(posedge clk);
      evMasterAbort <= 1'b0;
      rd(pcic_pkg::OFF_STATUS, 32'h1c0);
      chk(initIrq, 1'b0);
      bus(1'b1, pcic_pkg::OFF_STATUS, 32'h40);
   endtask
   // Limit 2: the third retry ends the transaction; bus error reply on
   task automatic t_retry;
      outFifoEmpty <= 1'b0;
      bus(1'b1, pcic_pkg::OFF_CONFIG, 32'h8b8);
      bus(1'b1, pcic_pkg::OFF_TIMEOUT, 32'h280);
      txnStart <= 1'b1;
      @(posedge clk);
      txnStart <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         retryTerm <= 1'b1;
         @(posedge clk);
         chk(retryTimeout, i == 2);
         retryTerm <= 1'b0;
         @(posedge clk);
      end
      readEnd <= 1'b1;
      @(posedge clk);
      readEnd <= 1'b0;
      @(posedge clk);
      chk({sysBusError, readDataInvalid}, 2'b10);
      rd(pcic_pkg::OFF_STATUS, 32'h0c1);
      outFifoEmpty <= 1'b1;
      bus(1'b1, pcic_pkg::OFF_STATUS, 32'h41);
   endtask
   // Ready limit 2, retry check off: one timeout on the third PCI rise
   task automatic t_ready;
      int n = 0;
      bus(1'b1, pcic_pkg::OFF_TIMEOUT, 32'h2);
      readyWait <= 1'b1;
      repeat (60) begin
         @(posedge clk);
         if (readyTimeout === 1'b1) begin
            n++;
         end
      end
      readyWait <= 1'b0;
      chk(n, 32'h1);
      rd(pcic_pkg::OFF_STATUS, 32'h1c2);
      bus(1'b1, pcic_pkg::OFF_STATUS, 32'h42);
   endtask
   task automatic t_serr;
      bus(1'b1, pcic_pkg::OFF_CONFIG, 32'h1);
      repeat (40) @(posedge clk);
      chk(lowClocks, 32'h1);
      rd(pcic_pkg::OFF_CONFIG, 32'h0);
   endtask
   task automatic t_sat;
      satelliteMode <= 1'b1;
      pciStatusFlags <= 6'h3f;
      powerState <= 2'h3;
      cfgWrReq <= 1'b1;
      repeat (5) @(posedge clk);
      chk(cfgWrAllow, 1'b0);
      rd(pcic_pkg::OFF_SHADOW, 32'h0300fb00);
      satelliteMode <= 1'b0;
      repeat (5) @(posedge clk);
      chk(cfgWrAllow, 1'b1);
   endtask
   // ----------------------------------------
   // Clock, ceiling and main sequence
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // A few hundred cycles are expected; far more means a hang
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         give_verdict();
      end
   end
   initial begin
      {rstn, hsel, hwrite, htrans, haddr, hwdata, pciBootStrap, satelliteMode} = '0;
      {txnStart, evMasterAbort, evTargetAbort, evParity, retryTerm, readyWait, readEnd} = '0;
      {reqValid, reqWindow, xferValid, xferSpecial, xferWindow, cfgWrReq} = '0;
      {pciStatusFlags, powerState} = '0;
      {bigEndianStrap, outFifoEmpty, inFifoEmpty} = 3'h7;
      xferData = 32'h11223344;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      repeat (5) @(posedge clk);
      t_reset();
      t_swap();
      t_flags();
      t_retry();
      t_ready();
      t_serr();
      t_sat();
      give_verdict();
   end
endmodule
